/* design/ifs_flag_bank.sv */
// Interrupt flag status bank: three flag registers behind an AHB-Lite slave
// How it works
// - Flag reads one after request, zero after clear
// - All flags clear at power-on reset
// - Implemented flags are software readable and writable
// - Register 0 bit 15 reads zero
// - Register 1 bit 2 reads zero
// - Register 2 bit 13 reads zero
// - Reg0: DMA1 bit 14, ADC1 bit 13
// - Reg0: UART1 transmit bit 12, receive 11
// - Reg0: SPI1 event 10, fault 9, timer3 8
// - Reg0 bits 7..3: T2, OC2, IC2, DMA0, T1
// - Reg0: OC1 bit 2, IC1 1, INT0 0
// - Reg1 bits 15..11: UART2 tx/rx, INT2, T5, T4
// - Reg1: OC4 10, OC3 9, DMA2 8
// - Reg1: IC8 7, IC7 6, ADC2 5, INT1 4
// - Reg1: change notify 3, I2C master 1, slave 0
// - Reg2: T6 15, DMA4 14, OC8..OC5 12..9
// - Reg2: IC6..IC3 at bits 8..5
// - Reg2 bits 4..0: DMA3, CAN event, CAN rx, SPI2
// - Hardware sets flags, software alone clears them
// - Same source order as enable and priority
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none

module ifs_flag_bank import ifs_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Request events from the peripherals, one-cycle or level, high active
    input wire logic dma_ch1_done_req,
    input wire logic adc_one_done_req,
    input wire logic uart_one_tx_req,
    input wire logic uart_one_rx_req,
    input wire logic spi_one_event_req,
    input wire logic spi_one_fault_req,
    input wire logic timer_three_req,
    input wire logic timer_two_req,
    input wire logic out_cmp_two_req,
    input wire logic in_cap_two_req,
    input wire logic dma_ch0_done_req,
    input wire logic timer_one_req,
    input wire logic out_cmp_one_req,
    input wire logic in_cap_one_req,
    input wire logic ext_irq_zero_req,
    input wire logic uart_two_tx_req,
    input wire logic uart_two_rx_req,
    input wire logic ext_irq_two_req,
    input wire logic timer_five_req,
    input wire logic timer_four_req,
    input wire logic out_cmp_four_req,
    input wire logic out_cmp_three_req,
    input wire logic dma_ch2_done_req,
    input wire logic in_cap_eight_req,
    input wire logic in_cap_seven_req,
    input wire logic adc_two_done_req,
    input wire logic ext_irq_one_req,
    input wire logic pin_change_req,
    input wire logic i2c_one_master_req,
    input wire logic i2c_one_slave_req,
    input wire logic timer_six_req,
    input wire logic dma_ch4_done_req,
    input wire logic out_cmp_eight_req,
    input wire logic out_cmp_seven_req,
    input wire logic out_cmp_six_req,
    input wire logic out_cmp_five_req,
    input wire logic in_cap_six_req,
    input wire logic in_cap_five_req,
    input wire logic in_cap_four_req,
    input wire logic in_cap_three_req,
    input wire logic dma_ch3_done_req,
    input wire logic can_one_event_req,
    input wire logic can_one_rx_ready_req,
    input wire logic spi_two_event_req,
    input wire logic spi_two_error_req,
    // Flag vectors towards the interrupt controller, same bit order as the registers
    output logic [FLAG_WIDTH-1:0] irq_flag_status_0,
    output logic [FLAG_WIDTH-1:0] irq_flag_status_1,
    output logic [FLAG_WIDTH-1:0] irq_flag_status_2
);

    // Decode a byte address into a one-hot register select; unmapped gives zero
    function automatic logic [REG_COUNT-1:0] ifs_decode(input logic [31:0] addr);
        logic [REG_COUNT-1:0] sel;
        sel = '0;
        // Anything above the decoded window is unmapped as well
        if (addr[31:ADDR_BITS] == '0) begin
            case (addr[ADDR_BITS-1:0])
                ADDR_FLAG_0: sel[0] = 1'b1;
                ADDR_FLAG_1: sel[1] = 1'b1;
                ADDR_FLAG_2: sel[2] = 1'b1;
                default: sel = '0;
            endcase
        end
        return sel;
    endfunction

    // Byte lanes touched by a transfer of the given size and low address
    function automatic logic [LANE_COUNT-1:0] ifs_lanes(input logic [2:0] size, input logic [1:0] low);
        logic [LANE_COUNT-1:0] lanes;
        lanes = '0;
        case (size)
            HSIZE_BYTE: lanes[low] = 1'b1;
            HSIZE_HALF: lanes = low[1] ? 4'hC : 4'h3;
            default: lanes = 4'hF;
        endcase
        return lanes;
    endfunction

    ifs_bus_state_type state_ff; // Registered bus slave state
    ifs_bus_state_type nxt_state; // Next bus slave state

    logic [REG_COUNT-1:0][FLAG_WIDTH-1:0] set_evt; // Events grouped per register
    logic [REG_COUNT-1:0][FLAG_WIDTH-1:0] flags; // Registered flags
    logic [REG_COUNT-1:0][FLAG_WIDTH-1:0] nxt_flags; // Flags after this cycle
    logic [REG_COUNT-1:0] wr_en; // Per-register write strobe
    logic addr_phase; // A valid transfer is being accepted this cycle

    localparam logic [REG_COUNT-1:0][FLAG_WIDTH-1:0] IMPL_MASKS = {IMPL_MASK_2, IMPL_MASK_1, IMPL_MASK_0};

    // Event placement for all three registers in one process, so set_evt has a single driver
    always_comb begin
        // Register 0 event placement; bit 15 has no source
        set_evt[0] = '0;
        set_evt[0][B_DMA_CH1_DONE] = dma_ch1_done_req;
        set_evt[0][B_ADC_ONE_DONE] = adc_one_done_req;
        set_evt[0][B_UART_ONE_TX] = uart_one_tx_req;
        set_evt[0][B_UART_ONE_RX] = uart_one_rx_req;
        set_evt[0][B_SPI_ONE_EVENT] = spi_one_event_req;
        set_evt[0][B_SPI_ONE_FAULT] = spi_one_fault_req;
        set_evt[0][B_TIMER_THREE] = timer_three_req;
        set_evt[0][B_TIMER_TWO] = timer_two_req;
        set_evt[0][B_OUT_CMP_TWO] = out_cmp_two_req;
        set_evt[0][B_IN_CAP_TWO] = in_cap_two_req;
        set_evt[0][B_DMA_CH0_DONE] = dma_ch0_done_req;
        set_evt[0][B_TIMER_ONE] = timer_one_req;
        set_evt[0][B_OUT_CMP_ONE] = out_cmp_one_req;
        set_evt[0][B_IN_CAP_ONE] = in_cap_one_req;
        set_evt[0][B_EXT_IRQ_ZERO] = ext_irq_zero_req;
        // Register 1 event placement; bit 2 has no source
        set_evt[1] = '0;
        set_evt[1][B_UART_TWO_TX] = uart_two_tx_req;
        set_evt[1][B_UART_TWO_RX] = uart_two_rx_req;
        set_evt[1][B_EXT_IRQ_TWO] = ext_irq_two_req;
        set_evt[1][B_TIMER_FIVE] = timer_five_req;
        set_evt[1][B_TIMER_FOUR] = timer_four_req;
        set_evt[1][B_OUT_CMP_FOUR] = out_cmp_four_req;
        set_evt[1][B_OUT_CMP_THREE] = out_cmp_three_req;
        set_evt[1][B_DMA_CH2_DONE] = dma_ch2_done_req;
        set_evt[1][B_IN_CAP_EIGHT] = in_cap_eight_req;
        set_evt[1][B_IN_CAP_SEVEN] = in_cap_seven_req;
        set_evt[1][B_ADC_TWO_DONE] = adc_two_done_req;
        set_evt[1][B_EXT_IRQ_ONE] = ext_irq_one_req;
        set_evt[1][B_PIN_CHANGE] = pin_change_req;
        set_evt[1][B_I2C_ONE_MASTER] = i2c_one_master_req;
        set_evt[1][B_I2C_ONE_SLAVE] = i2c_one_slave_req;
        // Register 2 event placement; bit 13 has no source
        set_evt[2] = '0;
        set_evt[2][B_TIMER_SIX] = timer_six_req;
        set_evt[2][B_DMA_CH4_DONE] = dma_ch4_done_req;
        set_evt[2][B_OUT_CMP_EIGHT] = out_cmp_eight_req;
        set_evt[2][B_OUT_CMP_SEVEN] = out_cmp_seven_req;
        set_evt[2][B_OUT_CMP_SIX] = out_cmp_six_req;
        set_evt[2][B_OUT_CMP_FIVE] = out_cmp_five_req;
        set_evt[2][B_IN_CAP_SIX] = in_cap_six_req;
        set_evt[2][B_IN_CAP_FIVE] = in_cap_five_req;
        set_evt[2][B_IN_CAP_FOUR] = in_cap_four_req;
        set_evt[2][B_IN_CAP_THREE] = in_cap_three_req;
        set_evt[2][B_DMA_CH3_DONE] = dma_ch3_done_req;
        set_evt[2][B_CAN_ONE_EVENT] = can_one_event_req;
        set_evt[2][B_CAN_ONE_RX_READY] = can_one_rx_ready_req;
        set_evt[2][B_SPI_TWO_EVENT] = spi_two_event_req;
        set_evt[2][B_SPI_TWO_ERROR] = spi_two_error_req;
    end

    // Write strobes land in the data phase, when hwdata is on the bus
    always_comb begin
        for (int r = 0; r < REG_COUNT; r++) begin
            wr_en[r] = state_ff.wr_pend && state_ff.wr_sel[r];
        end
    end

    // One flag register per index; masks keep absent bits at zero
    genvar gi;
    generate
        for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
            ifs_flag_reg #(
                .IMPL_MASK(IMPL_MASKS[gi])
            ) u_flag_reg (
                .hclk(hclk),
                .hresetn(hresetn),
                .set_evt(set_evt[gi]),
                .wr_en(wr_en[gi]),
                .wr_lanes(state_ff.wr_lanes[1:0]),
                .wr_data(hwdata[FLAG_WIDTH-1:0]),
                .flags(flags[gi]),
                .nxt_flags(nxt_flags[gi])
            );
        end
    endgenerate

    // Only NONSEQ or SEQ transfers with the bus ready are taken
    assign addr_phase = hsel && htrans[1] && hready;

    // Bus slave next state
    always_comb begin
        logic [REG_COUNT-1:0] sel;
        sel = ifs_decode(haddr);
        nxt_state = state_ff;
        // The slave never stalls, so hready stays high and the answer is always OKAY
        nxt_state.ready = 1'b1;
        nxt_state.resp = HRESP_OKAY;
        // A write lasts one data phase only
        nxt_state.wr_pend = 1'b0;
        nxt_state.wr_sel = '0;
        nxt_state.wr_lanes = '0;
        if (addr_phase) begin
            if (hwrite) begin
                // Unmapped writes get an empty select and change nothing
                nxt_state.wr_pend = 1'b1;
                nxt_state.wr_sel = sel;
                nxt_state.wr_lanes = ifs_lanes(hsize, haddr[1:0]);
            end else begin
                // Read sampled from next values, so a write in flight is seen;
                // the price is that the value is a snapshot at the address edge
                nxt_state.rd_data = '0;
                for (int r = 0; r < REG_COUNT; r++) begin
                    if (sel[r]) begin
                        nxt_state.rd_data[FLAG_WIDTH-1:0] = nxt_flags[r];
                    end
                end
            end
        end
    end

    // Bus slave registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff.wr_pend <= 1'b0;
            state_ff.wr_sel <= '0;
            state_ff.wr_lanes <= '0;
            state_ff.rd_data <= '0;
            state_ff.ready <= 1'b1;
            state_ff.resp <= HRESP_OKAY;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs come straight from registers
    assign hrdata = state_ff.rd_data;
    assign hreadyout = state_ff.ready;
    assign hresp = state_ff.resp;
    assign irq_flag_status_0 = flags[0];
    assign irq_flag_status_1 = flags[1];
    assign irq_flag_status_2 = flags[2];

endmodule

`default_nettype wire

/* design/ifs_pkg.sv */
// Package: register map, flag bit positions and state types for the interrupt flag status bank
package ifs_pkg;

    // Bus and register geometry
    localparam int REG_COUNT = 3; // Number of flag status registers
    localparam int FLAG_WIDTH = 16; // Implemented width of each flag register
    localparam int ADDR_BITS = 12; // Address bits decoded inside the slave window
    localparam int LANE_COUNT = 4; // Byte lanes of the 32-bit data bus
    localparam int LANE_BITS = 8; // Bits per byte lane

    // Byte addresses of the three flag registers
    localparam logic [ADDR_BITS-1:0] ADDR_FLAG_0 = 12'h000;
    localparam logic [ADDR_BITS-1:0] ADDR_FLAG_1 = 12'h004;
    localparam logic [ADDR_BITS-1:0] ADDR_FLAG_2 = 12'h008;

    // Implemented bits; unimplemented ones read zero and ignore writes
    localparam logic [15:0] IMPL_MASK_0 = 16'h7FFF; // Top bit absent
    localparam logic [15:0] IMPL_MASK_1 = 16'hFFFB; // Bit 2 absent
    localparam logic [15:0] IMPL_MASK_2 = 16'hDFFF; // Bit 13 absent
    localparam logic [15:0] FLAG_RESET = 16'h0000; // Power-on value of every flag

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;
    localparam logic HRESP_OKAY = 1'h0;

    // Flag register 0 bit positions
    localparam int B_DMA_CH1_DONE = 14;
    localparam int B_ADC_ONE_DONE = 13;
    localparam int B_UART_ONE_TX = 12;
    localparam int B_UART_ONE_RX = 11;
    localparam int B_SPI_ONE_EVENT = 10;
    localparam int B_SPI_ONE_FAULT = 9;
    localparam int B_TIMER_THREE = 8;
    localparam int B_TIMER_TWO = 7;
    localparam int B_OUT_CMP_TWO = 6;
    localparam int B_IN_CAP_TWO = 5;
    localparam int B_DMA_CH0_DONE = 4;
    localparam int B_TIMER_ONE = 3;
    localparam int B_OUT_CMP_ONE = 2;
    localparam int B_IN_CAP_ONE = 1;
    localparam int B_EXT_IRQ_ZERO = 0;

    // Flag register 1 bit positions
    localparam int B_UART_TWO_TX = 15;
    localparam int B_UART_TWO_RX = 14;
    localparam int B_EXT_IRQ_TWO = 13;
    localparam int B_TIMER_FIVE = 12;
    localparam int B_TIMER_FOUR = 11;
    localparam int B_OUT_CMP_FOUR = 10;
    localparam int B_OUT_CMP_THREE = 9;
    localparam int B_DMA_CH2_DONE = 8;
    localparam int B_IN_CAP_EIGHT = 7;
    localparam int B_IN_CAP_SEVEN = 6;
    localparam int B_ADC_TWO_DONE = 5;
    localparam int B_EXT_IRQ_ONE = 4;
    localparam int B_PIN_CHANGE = 3;
    localparam int B_I2C_ONE_MASTER = 1;
    localparam int B_I2C_ONE_SLAVE = 0;

    // Flag register 2 bit positions
    localparam int B_TIMER_SIX = 15;
    localparam int B_DMA_CH4_DONE = 14;
    localparam int B_OUT_CMP_EIGHT = 12;
    localparam int B_OUT_CMP_SEVEN = 11;
    localparam int B_OUT_CMP_SIX = 10;
    localparam int B_OUT_CMP_FIVE = 9;
    localparam int B_IN_CAP_SIX = 8;
    localparam int B_IN_CAP_FIVE = 7;
    localparam int B_IN_CAP_FOUR = 6;
    localparam int B_IN_CAP_THREE = 5;
    localparam int B_DMA_CH3_DONE = 4;
    localparam int B_CAN_ONE_EVENT = 3;
    localparam int B_CAN_ONE_RX_READY = 2;
    localparam int B_SPI_TWO_EVENT = 1;
    localparam int B_SPI_TWO_ERROR = 0;

    // State of one flag register
    typedef struct packed {
        logic [FLAG_WIDTH-1:0] flags;
    } ifs_reg_state_type;

    // State of the bus slave
    typedef struct packed {
        logic wr_pend; // Write data phase due this cycle
        logic [REG_COUNT-1:0] wr_sel; // One-hot target of the pending write
        logic [LANE_COUNT-1:0] wr_lanes; // Byte lanes of the pending write
        logic [31:0] rd_data; // Read data driven in the data phase
        logic ready; // Ready towards the master
        logic resp; // Response towards the master
    } ifs_bus_state_type;

endpackage

/* design/ifs_flag_reg.sv */
// One 16-bit interrupt flag register: hardware set, software read/write
`timescale 1ns/1ps
`default_nettype none

module ifs_flag_reg import ifs_pkg::*; #(
    parameter logic [FLAG_WIDTH-1:0] IMPL_MASK = 16'hFFFF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [FLAG_WIDTH-1:0] set_evt,
    input wire logic wr_en,
    input wire logic [1:0] wr_lanes,
    input wire logic [FLAG_WIDTH-1:0] wr_data,
    output logic [FLAG_WIDTH-1:0] flags,
    output logic [FLAG_WIDTH-1:0] nxt_flags
);

    ifs_reg_state_type state_ff; // Registered flags
    ifs_reg_state_type nxt_state; // Next flags

    // Software write per lane first, then hardware events on top
    always_comb begin
        logic [FLAG_WIDTH-1:0] base;
        base = state_ff.flags;
        for (int lane = 0; lane < 2; lane++) begin
            // Only lanes the bus actually strobed are touched
            if (wr_en && wr_lanes[lane]) begin
                base[lane*LANE_BITS +: LANE_BITS] = wr_data[lane*LANE_BITS +: LANE_BITS];
            end
        end
        // Set wins over a same-cycle software clear, so no request is lost
        nxt_state.flags = (base | set_evt) & IMPL_MASK;
    end

    // Flag storage, zero at power-on reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff.flags <= FLAG_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign flags = state_ff.flags;
    assign nxt_flags = nxt_state.flags;

endmodule

`default_nettype wire

/* test/ifs_flag_bank_sva.sv */
// Concurrent checks on the ports of the interrupt flag status bank
`timescale 1ns/1ps
`default_nettype none
module ifs_flag_bank_sva import ifs_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic dma_ch1_done_req,
    input wire logic ext_irq_zero_req,
    input wire logic pin_change_req,
    input wire logic timer_six_req,
    input wire logic [FLAG_WIDTH-1:0] irq_flag_status_0,
    input wire logic [FLAG_WIDTH-1:0] irq_flag_status_1,
    input wire logic [FLAG_WIDTH-1:0] irq_flag_status_2
);
    // All checks run on the bus clock and sleep while reset is low
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Write address phase to register 0 taken by the slave
    sequence s_wr0;
        hsel && htrans[1] && hready && hwrite && haddr == {20'h00000, ADDR_FLAG_0};
    endsequence
    // Read address phase to register 2 taken by the slave
    sequence s_rd2;
        hsel && htrans[1] && hready && !hwrite && haddr == {20'h00000, ADDR_FLAG_2};
    endsequence
    AST_SET_REG0: assert property (ext_irq_zero_req |=> irq_flag_status_0[0])
        else $error("external irq zero flag missed its request");
    AST_SET_REG1: assert property (pin_change_req |=> irq_flag_status_1[3])
        else $error("pin change flag missed its request");
    AST_SET_REG2: assert property (timer_six_req |=> irq_flag_status_2[15])
        else $error("timer six flag missed its request");
    AST_CLEAR_ONLY_BY_WRITE: assert property ($fell(irq_flag_status_0[14]) |->
        $past(hsel && htrans[1] && hwrite && haddr == {20'h00000, ADDR_FLAG_0}, 2) && !$past(hwdata[14]))
        else $error("dma channel one flag dropped without a software clear");
    AST_WRITE_ONE: assert property (s_wr0 ##1 hwdata[14] |=> irq_flag_status_0[14])
        else $error("written one not held in register 0");
    AST_WRITE_ZERO: assert property (s_wr0 ##1 (!hwdata[14] && !dma_ch1_done_req) |=> !irq_flag_status_0[14])
        else $error("written zero did not clear register 0");
    AST_ABSENT_BITS: assert property (!irq_flag_status_0[15] && !irq_flag_status_1[2] && !irq_flag_status_2[13])
        else $error("unimplemented flag bit seen high");
    AST_READ_REG2: assert property (s_rd2 |=> hrdata == {16'h0000, irq_flag_status_2})
        else $error("register 2 read data differs from its flags");
    AST_BUS_OKAY: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("slave stalled or answered with an error");
endmodule
bind ifs_flag_bank ifs_flag_bank_sva i_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .dma_ch1_done_req(dma_ch1_done_req),
    .ext_irq_zero_req(ext_irq_zero_req), .pin_change_req(pin_change_req), .timer_six_req(timer_six_req),
    .irq_flag_status_0(irq_flag_status_0), .irq_flag_status_1(irq_flag_status_1),
    .irq_flag_status_2(irq_flag_status_2));
`default_nettype wire

/* test/ifs_periph_model.sv */
// Behavioural peripherals that raise request events on command
`timescale 1ns/1ps
`default_nettype none
module ifs_periph_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic slow,
    input wire logic [47:0] fire,
    output logic [47:0] req
);
    logic [47:0] req_ff; // Request lines seen by the bank
    logic [47:0] last_ff; // Previous command, used to stretch slow sources
    // A command shows one edge later; a slow source keeps its line up a second cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_ff <= 48'h000000000000;
            last_ff <= 48'h000000000000;
        end else begin
            req_ff <= fire | (slow ? last_ff : 48'h000000000000);
            last_ff <= fire;
        end
    end
    assign req = req_ff;
endmodule
`default_nettype wire

/* test/ifs_flag_bank_tb.sv */
// Self-checking bench for the interrupt flag status bank
`timescale 1ns/1ps
`default_nettype none
module ifs_flag_bank_tb import ifs_pkg::*;;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [47:0] fire, ev;
    logic [15:0] f0, f1, f2;
    logic [15:0] mask [3] = '{IMPL_MASK_0, IMPL_MASK_1, IMPL_MASK_2}; // Readable bits per register
    logic [31:0] adr [3] = '{32'h00000000, 32'h00000004, 32'h00000008}; // Register byte addresses
    int bad_count = 0;
    int n_compared = 0;

    ifs_periph_model i_periph (.hclk(hclk), .hresetn(hresetn), .slow(slow), .fire(fire), .req(ev));

    // Literal bit numbers here, so a slip in the source map shows up as a wrong flag
    ifs_flag_bank i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .dma_ch1_done_req(ev[14]), .adc_one_done_req(ev[13]), .uart_one_tx_req(ev[12]),
        .uart_one_rx_req(ev[11]), .spi_one_event_req(ev[10]), .spi_one_fault_req(ev[9]),
        .timer_three_req(ev[8]), .timer_two_req(ev[7]), .out_cmp_two_req(ev[6]), .in_cap_two_req(ev[5]),
        .dma_ch0_done_req(ev[4]), .timer_one_req(ev[3]), .out_cmp_one_req(ev[2]), .in_cap_one_req(ev[1]),
        .ext_irq_zero_req(ev[0]), .uart_two_tx_req(ev[31]), .uart_two_rx_req(ev[30]),
        .ext_irq_two_req(ev[29]), .timer_five_req(ev[28]), .timer_four_req(ev[27]),
        .out_cmp_four_req(ev[26]), .out_cmp_three_req(ev[25]), .dma_ch2_done_req(ev[24]),
        .in_cap_eight_req(ev[23]), .in_cap_seven_req(ev[22]), .adc_two_done_req(ev[21]),
        .ext_irq_one_req(ev[20]), .pin_change_req(ev[19]), .i2c_one_master_req(ev[17]),
        .i2c_one_slave_req(ev[16]), .timer_six_req(ev[47]), .dma_ch4_done_req(ev[46]),
        .out_cmp_eight_req(ev[44]), .out_cmp_seven_req(ev[43]), .out_cmp_six_req(ev[42]),
        .out_cmp_five_req(ev[41]), .in_cap_six_req(ev[40]), .in_cap_five_req(ev[39]),
        .in_cap_four_req(ev[38]), .in_cap_three_req(ev[37]), .dma_ch3_done_req(ev[36]),
        .can_one_event_req(ev[35]), .can_one_rx_ready_req(ev[34]), .spi_two_event_req(ev[33]),
        .spi_two_error_req(ev[32]), .irq_flag_status_0(f0), .irq_flag_status_1(f1), .irq_flag_status_2(f2));

    // 50 MHz bus clock
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // Prints the verdict and stops the run
    task give_verdict;
        if (bad_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One comparison, reported at once on mismatch
    task chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Single AHB-Lite word transfer; e is fired with the address phase so it lands in the data phase
    task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [47:0] e);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        fire <= e;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= HTRANS_IDLE;
        hsel <= 1'b0;
        hwdata <= d;
        fire <= 48'h000000000000;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        #1;
    endtask

    // Power-on values of all three registers
    task t_reset;
        for (int i = 0; i < 3; i++) begin
            xfer(1'b0, adr[i], 32'h0, 48'h0);
            chk("reset read", 48'h0, rd);
        end
        chk("reset outputs", 48'h0, {f2, f1, f0});
    endtask

    // Ones and zeros written and read back; absent bits and unmapped address stay zero
    task t_rw;
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, adr[i], 32'hFFFFFFFF, 48'h0);
            xfer(1'b0, adr[i], 32'h0, 48'h0);
            chk("write ones", mask[i], rd);
            xfer(1'b1, adr[i], 32'h0, 48'h0);
            xfer(1'b0, adr[i], 32'h0, 48'h0);
            chk("write zeros", 48'h0, rd);
        end
        xfer(1'b1, 32'h0000000C, 32'hFFFFFFFF, 48'h0);
        xfer(1'b0, 32'h0000000C, 32'h0, 48'h0);
        chk("unmapped read", 48'h0, {rd, f2});
    endtask

    // Every source sets exactly its own bit and a software write clears it
    task t_map;
        logic [47:0] exp;
        for (int i = 0; i < 3; i++) begin
            for (int b = 0; b < 16; b++) begin
                if (mask[i][b]) begin
                    exp = 48'h1 << (16 * i + b);
                    @(posedge hclk);
                    fire <= exp;
                    @(posedge hclk);
                    fire <= 48'h0;
                    @(posedge hclk);
                    #1;
                    chk("flag outputs", exp, {f2, f1, f0});
                    xfer(1'b0, adr[i], 32'h0, 48'h0);
                    chk("flag read", 48'h1 << b, rd);
                    xfer(1'b1, adr[i], 32'h0, 48'h0);
                    chk("flag cleared", 48'h0, {f2, f1, f0});
                end
            end
        end
    endtask

    // A slow source: flag stays up long after its request ends
    task t_sticky;
        slow <= 1'b1;
        xfer(1'b0, adr[1], 32'h0, 48'h000000080000);
        repeat (6) @(posedge hclk);
        #1;
        chk("sticky flag", 48'h000000080000, {f2, f1, f0});
        slow <= 1'b0;
        xfer(1'b1, adr[1], 32'h0, 48'h0);
        chk("sticky cleared", 48'h0, {f2, f1, f0});
    endtask

    // Event in the same cycle as a clearing write must survive
    task t_set_wins;
        xfer(1'b1, adr[0], 32'h0, 48'h1);
        chk("set beats clear", 48'h1, {f2, f1, f0});
        xfer(1'b1, adr[0], 32'h0, 48'h0);
        chk("later clear", 48'h0, {f2, f1, f0});
    endtask

    // Reset in mid-run drops every flag without a clock edge
    task t_second_reset;
        xfer(1'b1, adr[2], 32'h0000FFFF, 48'h0);
        @(posedge hclk);
        hresetn <= 1'b0;
        #1;
        chk("mid-run reset", 48'h0, {f2, f1, f0});
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, adr[2], 32'h0, 48'h0);
        chk("read after reset", 48'h0, rd);
    endtask

    // Main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = HTRANS_IDLE;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        fire = 48'h0;
        slow = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_rw();
        t_map();
        t_sticky();
        t_set_wins();
        t_second_reset();
        give_verdict();
    end

    // Watchdog: the run needs about 500 cycles, so 10000 means a hang
    initial begin
        #200000;
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
